/* File: src/serial_control.v */
// Behaviour
// - control register resets and standby-clears to zero
// - cpu reads and writes control freely
// - bit 7 gates transmit-empty request
// - transmit-empty request drops on flag clear or disable
// - bit 6 gates receive-full and receive-error requests
// - receive requests drop on flag clear or disable
// - transmit disabled forces buffer-empty flag high
// - transmission starts once buffer-empty flag clears
// - receive disable keeps receive flags unchanged
// - receiver starts on start bit or clock; here it starts only on a low start bit, in sync mode too
// - address-wait works only async with address mode
// - address word clears address-wait, resumes reception
// - bit 2 gates transmit-end request
// - transmit-end request drops on flags clear or disable
// - bits 1,0 pick clock source and pin direction
// - clock-out bit only async with internal clock
// - clock output runs at bit rate
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctrl_map.vh"
module serial_control #(
   parameter integer CLK_HZ = `CLK_HZ,
   parameter integer BIT_RATE = `BIT_RATE
) (
   // clock and reset
   input wire core_clk,
   input wire rst_n,
   input wire clk_en,
   input wire standby,
   // avalon-mm slave
   input wire [4:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output wire waitrequest,
   // serial pins
   input wire rxd_pin,
   output reg txd_pin,
   input wire sck_in,
   output reg sck_out,
   output wire sck_oe_n,
   // interrupt requests
   output wire tx_empty_irq,
   output wire rx_full_irq,
   output wire rx_error_irq,
   output wire tx_end_irq
);
   localparam integer DIV = CLK_HZ / (BIT_RATE * 16) < 1 ? 1 :
      CLK_HZ / (BIT_RATE * 16);
   localparam [3:0] S_IDLE = 4'b0001;
   localparam [3:0] S_DATA = 4'b0010;
   localparam [3:0] S_PAR = 4'b0100;
   localparam [3:0] S_STOP = 4'b1000;

   reg [7:0] serial_control_reg;
   reg [7:0] serial_mode_reg;
   reg [7:0] tx_holding_reg, tx_shift_reg, rx_holding_reg, rx_shift_reg;
   reg tx_buf_empty, rx_buf_full, overrun_err, framing_err, parity_err;
   reg tx_end_flag, rx_addr_bit, tx_addr_bit;
   reg [4:0] seen_reg; // read-as-one memory for clear-by-zero flags
   reg acked_reg;
   reg [1:0] rx_sync, sck_sync;
   reg sck_prev;
   reg [15:0] div_cnt;
   reg tick16;
   reg [3:0] tx_os, rx_os;
   reg [3:0] tx_state, rx_state;
   reg [3:0] tx_cnt, rx_cnt;
   reg rx_par_bit, rx_abit;
   reg [15:0] bitclk_cnt;

   wire tx_empty_irq_en = serial_control_reg[`CTL_TIE];
   wire rx_irq_en = serial_control_reg[`CTL_RIE];
   wire txen = serial_control_reg[`CTL_TXEN];
   wire rxen = serial_control_reg[`CTL_RXEN];
   wire tx_end_irq_en = serial_control_reg[`CTL_TX_END_IRQ_EN];
   wire csrc = serial_control_reg[`CTL_CSRC];
   wire cout = serial_control_reg[`CTL_COUT];
   wire sync_mode = serial_mode_reg[`MD_SYNC];
   wire addr_mode_bit = serial_mode_reg[`MD_AMODE] & ~sync_mode;
   wire addr_wait = serial_control_reg[`CTL_AWAIT] & addr_mode_bit;
   wire rxd = rx_sync[1];
   wire sck_rise = sck_sync[1] & ~sck_prev;

   // one-cycle answer: request taken on the edge after it appears
   assign waitrequest = (read | write) & ~acked_reg;
   wire wr = write & ~acked_reg;
   wire rd = read & ~acked_reg;
   wire [7:0] wd = writedata[7:0];

   // 16x tick from internal divider or external sck edges
   wire ext_clk = csrc;
   wire os_tick = ext_clk ? sck_rise : tick16;

   // pin direction: drive only async, internal, clock-out chosen
   wire drive_sck = ~csrc & cout & ~sync_mode;
   assign sck_oe_n = ~drive_sck;

   // level requests, no extra latching
   assign tx_empty_irq = tx_empty_irq_en & tx_buf_empty;
   assign rx_full_irq = rx_irq_en & rx_buf_full & ~addr_wait;
   assign rx_error_irq = rx_irq_en & (overrun_err | framing_err | parity_err)
      & ~addr_wait;
   assign tx_end_irq = tx_end_irq_en & tx_end_flag;

   wire [7:0] status_view = {tx_buf_empty, rx_buf_full, overrun_err,
      framing_err, parity_err, tx_end_flag, rx_addr_bit, tx_addr_bit};

   // receive word completion
   wire rx_done = rx_state == S_STOP && rx_os == 4'h7 && os_tick;
   wire is_addr_word = addr_mode_bit & rx_abit;
   wire rx_accept = rx_done & (~addr_wait | is_addr_word);
   wire tx_load = txen & ~tx_buf_empty & tx_state == S_IDLE;
   wire tx_last = tx_state == S_STOP && tx_os == 4'hF && os_tick;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_control_reg <= `CONTROL_RST;
         serial_mode_reg <= `MODE_RST;
         {tx_buf_empty, rx_buf_full, overrun_err, framing_err, parity_err,
            tx_end_flag, rx_addr_bit, tx_addr_bit} <= `STATUS_RST;
         seen_reg <= 5'h0;
         acked_reg <= 1'b0;
         tx_holding_reg <= 8'h00;
         rx_holding_reg <= 8'h00;
         readdata <= 32'h0000_0000;
      end else if (clk_en) begin
         acked_reg <= (rd | wr);
         if (standby) begin
            serial_control_reg <= `CONTROL_RST;
            {tx_buf_empty, rx_buf_full, overrun_err, framing_err,
               parity_err, tx_end_flag, rx_addr_bit, tx_addr_bit}
               <= `STATUS_RST;
            seen_reg <= 5'h0;
         end else begin
            if (rd) begin
               case (address)
                  `ADDR_CONTROL: readdata <= {24'h0, serial_control_reg};
                  `ADDR_STATUS: begin
                     readdata <= {24'h0, status_view};
                     seen_reg <= seen_reg | status_view[7:3];
                  end
                  `ADDR_TXDATA: readdata <= {24'h0, tx_holding_reg};
                  `ADDR_RXDATA: readdata <= {24'h0, rx_holding_reg};
                  `ADDR_MODE: readdata <= {24'h0, serial_mode_reg};
                  default: readdata <= 32'h0000_0000;
               endcase
            end
            if (wr && address == `ADDR_CONTROL)
               serial_control_reg <= wd;
            if (wr && address == `ADDR_MODE)
               serial_mode_reg <= wd;
            if (wr && address == `ADDR_TXDATA)
               tx_holding_reg <= wd;
            if (wr && address == `ADDR_STATUS) begin
               // clear only after seen as one
               if (!wd[`ST_TXE] && seen_reg[4]) begin
                  tx_buf_empty <= 1'b0;
                  seen_reg[4] <= 1'b0;
               end
               if (!wd[`ST_RXF] && seen_reg[3]) begin
                  rx_buf_full <= 1'b0;
                  seen_reg[3] <= 1'b0;
               end
               if (!wd[`ST_ORE] && seen_reg[2]) begin
                  overrun_err <= 1'b0;
                  seen_reg[2] <= 1'b0;
               end
               if (!wd[`ST_FE] && seen_reg[1]) begin
                  framing_err <= 1'b0;
                  seen_reg[1] <= 1'b0;
               end
               if (!wd[`ST_PE] && seen_reg[0]) begin
                  parity_err <= 1'b0;
                  seen_reg[0] <= 1'b0;
               end
               if (!wd[`ST_TXE] && seen_reg[4])
                  tx_end_flag <= 1'b0;
               tx_addr_bit <= wd[`ST_ADDRT];
            end
            // hardware sets after clears so a same-cycle event wins
            if (tx_load)
               tx_buf_empty <= 1'b1;
            if (!txen)
               tx_buf_empty <= 1'b1;
            if (tx_load)
               tx_end_flag <= 1'b0;
            if (tx_last && tx_buf_empty)
               tx_end_flag <= 1'b1;
            // receive disable leaves flags alone
            if (rx_accept) begin
               if (is_addr_word) begin
                  rx_addr_bit <= 1'b1;
                  serial_control_reg[`CTL_AWAIT] <= 1'b0;
               end else if (addr_mode_bit)
                  rx_addr_bit <= 1'b0;
               if (rx_buf_full)
                  overrun_err <= 1'b1;
               else begin
                  rx_holding_reg <= rx_shift_reg;
                  rx_buf_full <= 1'b1;
               end
               if (!rxd)
                  framing_err <= 1'b1;
               if (rx_par_bit && !addr_mode_bit && !sync_mode)
                  parity_err <= 1'b1;
            end
         end
      end
   end

   // synchronisers, baud divider, bit-rate clock out
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sync <= 2'b11;
         sck_sync <= 2'b00;
         sck_prev <= 1'b0;
         div_cnt <= 16'h0000;
         tick16 <= 1'b0;
         bitclk_cnt <= 16'h0000;
         sck_out <= 1'b0;
      end else if (clk_en) begin
         rx_sync <= {rx_sync[0], rxd_pin};
         sck_sync <= {sck_sync[0], sck_in};
         sck_prev <= sck_sync[1];
         tick16 <= 1'b0;
         if (div_cnt == DIV[15:0] - 16'h0001) begin
            div_cnt <= 16'h0000;
            tick16 <= 1'b1;
            // eight ticks per half bit gives a bit-rate clock
            if (bitclk_cnt == 16'h0007) begin
               bitclk_cnt <= 16'h0000;
               sck_out <= ~sck_out & drive_sck;
            end else
               bitclk_cnt <= bitclk_cnt + 16'h0001;
         end else
            div_cnt <= div_cnt + 16'h0001;
         // park low at once when released, never left high
         if (!drive_sck)
            sck_out <= 1'b0;
      end
   end

   // transmitter: start, 8 data, optional address bit, stop
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state <= S_IDLE;
         tx_shift_reg <= 8'h00;
         tx_cnt <= 4'h0;
         tx_os <= 4'h0;
         txd_pin <= 1'b1;
      end else if (clk_en) begin
         if (standby || !txen) begin
            tx_state <= S_IDLE;
            txd_pin <= 1'b1;
         end else case (tx_state)
            S_IDLE: if (tx_load) begin
               tx_shift_reg <= tx_holding_reg;
               tx_state <= S_DATA;
               tx_cnt <= 4'h0;
               tx_os <= 4'h0;
               txd_pin <= 1'b0;
            end
            S_DATA: if (os_tick) begin
               tx_os <= tx_os + 4'h1;
               if (tx_os == 4'hF) begin
                  txd_pin <= tx_shift_reg[0];
                  tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                  tx_cnt <= tx_cnt + 4'h1;
                  if (tx_cnt == 4'h8) begin
                     tx_state <= addr_mode_bit ? S_PAR : S_STOP;
                     txd_pin <= addr_mode_bit ? tx_addr_bit : 1'b1;
                  end
               end
            end
            S_PAR: if (os_tick) begin
               tx_os <= tx_os + 4'h1;
               if (tx_os == 4'hF) begin
                  tx_state <= S_STOP;
                  txd_pin <= 1'b1;
               end
            end
            S_STOP: if (os_tick) begin
               tx_os <= tx_os + 4'h1;
               if (tx_os == 4'hF)
                  tx_state <= S_IDLE;
            end
            default: tx_state <= S_IDLE;
         endcase
      end
   end

   // receiver; address-wait words are shifted but not delivered
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_state <= S_IDLE;
         rx_shift_reg <= 8'h00;
         rx_cnt <= 4'h0;
         rx_os <= 4'h0;
         rx_par_bit <= 1'b0;
         rx_abit <= 1'b0;
      end else if (clk_en) begin
         if (standby || !rxen)
            rx_state <= S_IDLE;
         else case (rx_state)
            S_IDLE: if (os_tick && !rxd) begin
               rx_state <= S_DATA;
               rx_os <= 4'h0;
               rx_cnt <= 4'h0;
               rx_abit <= 1'b0;
               rx_par_bit <= 1'b0;
            end
            S_DATA: if (os_tick) begin
               rx_os <= rx_os + 4'h1;
               if (rx_os == 4'h7 && rx_cnt == 4'h0 && rxd)
                  rx_state <= S_IDLE;
               else if (rx_os == 4'h7 && rx_cnt != 4'h0) begin
                  rx_shift_reg <= {rxd, rx_shift_reg[7:1]};
                  rx_par_bit <= rx_par_bit ^ rxd;
               end
               if (rx_os == 4'hF) begin
                  rx_cnt <= rx_cnt + 4'h1;
                  if (rx_cnt == 4'h8)
                     rx_state <= addr_mode_bit ? S_PAR : S_STOP;
               end
            end
            S_PAR: if (os_tick) begin
               rx_os <= rx_os + 4'h1;
               if (rx_os == 4'h7)
                  rx_abit <= rxd;
               if (rx_os == 4'hF)
                  rx_state <= S_STOP;
            end
            S_STOP: if (os_tick) begin
               rx_os <= rx_os + 4'h1;
               if (rx_os == 4'h7)
                  rx_state <= S_IDLE;
            end
            default: rx_state <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: src/serial_ctrl_map.vh */
`ifndef SERIAL_CTRL_MAP_VH
`define SERIAL_CTRL_MAP_VH
// byte addresses on the register bus
`define ADDR_CONTROL 5'h00
`define ADDR_STATUS 5'h04
`define ADDR_TXDATA 5'h08
`define ADDR_RXDATA 5'h0C
`define ADDR_MODE 5'h10
// control bit positions
`define CTL_TIE 7
`define CTL_RIE 6
`define CTL_TXEN 5
`define CTL_RXEN 4
`define CTL_AWAIT 3
`define CTL_TX_END_IRQ_EN 2
`define CTL_CSRC 1
`define CTL_COUT 0
// status bit positions
`define ST_TXE 7
`define ST_RXF 6
`define ST_ORE 5
`define ST_FE 4
`define ST_PE 3
`define ST_TX_END_FLAG 2
`define ST_ADDR 1
`define ST_ADDRT 0
// mode bit positions
`define MD_SYNC 7
`define MD_AMODE 2
// reset values
`define CONTROL_RST 8'h00
`define STATUS_RST 8'h84
`define MODE_RST 8'h00
// link timing
`define CLK_HZ 10000000
`define BIT_RATE 9600
`define EXT_OVERSAMPLE 16
`endif

/* File: testbench/serial_control_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_control_assertions #(
   parameter integer CLK_HZ = 10000000,
   parameter integer BIT_RATE = 9600
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic standby,
   // register bus
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // serial pins
   input wire logic txd_pin,
   input wire logic sck_out,
   input wire logic sck_oe_n,
   // requests
   input wire logic tx_empty_irq,
   input wire logic rx_full_irq,
   input wire logic rx_error_irq,
   input wire logic tx_end_irq
);
   // divider truncates, so the bit time is a multiple of 16
   localparam int BIT_CYC = CLK_HZ / (16 * BIT_RATE) * 16;
   localparam int LO = BIT_CYC - 17;
   localparam int HI = BIT_CYC - 1;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   a_wait_first: assert property ($rose(read || write) |-> waitrequest)
      else $error("request answered without a wait");
   a_wait_one: assert property ((read || write) && waitrequest
      |=> !waitrequest)
      else $error("request waited more than one cycle");
   a_idle_free: assert property (!(read || write) |-> !waitrequest)
      else $error("wait shown with no request");
   a_upper_zero: assert property (~|readdata[31:8])
      else $error("read data upper bits not zero");
   a_unmapped_zero: assert property (read && !waitrequest && address > 5'h10
      |-> readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_sck_quiet: assert property (sck_oe_n && $past(sck_oe_n)
      |-> !sck_out)
      else $error("clock pin toggled while not driven");
   a_sck_rate: assert property ($rose(sck_out) |=> (!$rose(sck_out))[*8]
      ##[LO:HI] ($rose(sck_out) || sck_oe_n))
      else $error("output clock not at bit rate");
   a_start_low: assert property ($fell(txd_pin) |-> (!txd_pin)[*8])
      else $error("transmit bit too short");
   a_standby_quiet: assert property (standby |=> !(tx_empty_irq || rx_full_irq
      || rx_error_irq || tx_end_irq))
      else $error("request left after standby");
   c_tx_end: cover property ($rose(tx_end_irq));
   c_rx_full: cover property ($rose(rx_full_irq));
   c_rx_err: cover property ($rose(rx_error_irq));
endmodule
bind serial_control serial_control_assertions #(.CLK_HZ(CLK_HZ),
   .BIT_RATE(BIT_RATE)) serial_control_assertions_i (
   .core_clk(core_clk), .rst_n(rst_n), .standby(standby),
   .address(address), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest), .txd_pin(txd_pin), .sck_out(sck_out),
   .sck_oe_n(sck_oe_n), .tx_empty_irq(tx_empty_irq),
   .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq),
   .tx_end_irq(tx_end_irq));
`default_nettype wire

/* File: testbench/serial_station.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_station #(
   parameter integer BIT_NS = 12800
) (
   // serial pins
   output logic rxd_pin,
   output logic sck_in,
   input wire logic txd_pin
);
   logic sck_run;
   logic [7:0] got;
   initial begin
      rxd_pin = 1'b1;
      sck_in = 1'b0;
      sck_run = 1'b0;
      got = 8'h00;
   end
   // sixteen ticks a bit, only within frames
   always #400 if (sck_run) sck_in = ~sck_in;
   // frame: start, 8 data lsb first, slot 9, slot 10
   task automatic send(input logic [7:0] d, input logic s9, input logic s10);
      logic [10:0] f;
      f = {s10, s9, d, 1'b0};
      sck_run = 1'b1;
      for (int i = 0; i < 11; i++) begin
         rxd_pin = f[i];
         #(BIT_NS);
      end
      sck_run = 1'b0;
   endtask
   always begin
      @(negedge txd_pin);
      #(BIT_NS * 3 / 2);
      for (int i = 0; i < 8; i++) begin
         got[i] = txd_pin;
         #(BIT_NS);
      end
   end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctrl_map.vh"
module testbench;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic standby = 1'b0;
   logic [4:0] address = 5'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [31:0] readdata;
   logic waitrequest, rxd_pin, txd_pin, sck_in, sck_out, sck_oe_n;
   logic tx_empty_irq, rx_full_irq, rx_error_irq, tx_end_irq;
   logic [7:0] rv;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   // control, then txe, tx_end_irq, rxf, err, oe_n
   localparam logic [12:0] ROWS [9] = '{13'h1011, 13'h0089, 13'h0020,
      13'h0061, 13'h0041, 13'h0801, 13'h0401, 13'h1499, 13'h0001};
   serial_control #(.BIT_RATE(78125)) serial_control_i (
      .core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .standby(standby),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .rxd_pin(rxd_pin),
      .txd_pin(txd_pin), .sck_in(sck_in), .sck_out(sck_out),
      .sck_oe_n(sck_oe_n), .tx_empty_irq(tx_empty_irq),
      .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq),
      .tx_end_irq(tx_end_irq));
   serial_station #(.BIT_NS(12800)) serial_station_i (
      .rxd_pin(rxd_pin), .sck_in(sck_in), .txd_pin(txd_pin));
   always #50 core_clk = ~core_clk;
   task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one idle cycle first, so strobes never change twice in one step
   // only the bench timeout ends a wait
   task automatic bus(input logic wr, input logic [4:0] a,
      input logic [7:0] d);
      @(posedge core_clk);
      address <= a;
      writedata <= {24'h00_0000, d};
      read <= !wr;
      write <= wr;
      do begin
         @(posedge core_clk);
      end while (waitrequest !== 1'b0);
      rv = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic irqs(input logic [7:0] exp);
      chk("irqs", {4'h0, tx_empty_irq, tx_end_irq, rx_full_irq,
         rx_error_irq}, exp);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         bad_count++;
         close_out();
      end
   end
   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (ROWS[i]) begin
         bus(1'b1, `ADDR_CONTROL, ROWS[i][12:5]);
         bus(1'b0, `ADDR_CONTROL, 8'h00);
         chk("control", rv, ROWS[i][12:5]);
         repeat (300) @(posedge core_clk);
         chk("pins", {3'h0, tx_empty_irq, tx_end_irq, rx_full_irq,
            rx_error_irq, sck_oe_n}, {3'h0, ROWS[i][4:0]});
      end
      bus(1'b1, `ADDR_CONTROL, 8'hE5);
      standby <= 1'b1;
      @(posedge core_clk);
      standby <= 1'b0;
      bus(1'b0, `ADDR_CONTROL, 8'h00);
      chk("standby", rv, 8'h00);
      bus(1'b1, 5'h14, 8'hFF);
      bus(1'b0, 5'h14, 8'h00);
      chk("unmapped", rv, 8'h00);
      bus(1'b0, `ADDR_CONTROL, 8'h00);
      chk("control", rv, 8'h00);
      // sync mode must keep the clock pin released
      bus(1'b1, `ADDR_CONTROL, 8'h01);
      bus(1'b1, `ADDR_MODE, 8'h80);
      chk("sync_oe", {7'h00, sck_oe_n}, 8'h01);
      bus(1'b1, `ADDR_CONTROL, 8'h00);
      bus(1'b1, `ADDR_MODE, 8'h00);
      bus(1'b1, `ADDR_CONTROL, 8'hA4);
      bus(1'b1, `ADDR_TXDATA, 8'h5A);
      bus(1'b0, `ADDR_STATUS, 8'h00);
      bus(1'b1, `ADDR_STATUS, 8'h00);
      chk("tx_end_flag", {7'h00, tx_end_irq}, 8'h00);
      repeat (1600) @(posedge core_clk);
      chk("line", serial_station_i.got, 8'h5A);
      irqs(8'h0C);
      bus(1'b1, `ADDR_CONTROL, 8'h24);
      irqs(8'h04);
      bus(1'b1, `ADDR_CONTROL, 8'h20);
      irqs(8'h00);
      // external clock: the receiver runs only off the station's ticks
      bus(1'b1, `ADDR_CONTROL, 8'h52);
      serial_station_i.send(8'hA3, 1'b1, 1'b1);
      irqs(8'h02);
      bus(1'b1, `ADDR_CONTROL, 8'h42);
      bus(1'b0, `ADDR_STATUS, 8'h00);
      chk("status", rv, 8'hC4);
      irqs(8'h02);
      bus(1'b1, `ADDR_CONTROL, 8'h02);
      irqs(8'h00);
      bus(1'b0, `ADDR_RXDATA, 8'h00);
      chk("rxdata", rv, 8'hA3);
      bus(1'b1, `ADDR_CONTROL, 8'h52);
      bus(1'b1, `ADDR_STATUS, 8'h00);
      irqs(8'h00);
      bus(1'b0, `ADDR_STATUS, 8'h00);
      chk("status", rv, 8'h80);
      serial_station_i.send(8'h11, 1'b0, 1'b1);
      // zero stop bit: word still lands, so both requests stand
      irqs(8'h03);
      // receiver off too: the low stop bit restarts it mid-frame
      bus(1'b1, `ADDR_CONTROL, 8'h02);
      irqs(8'h00);
      bus(1'b0, `ADDR_STATUS, 8'h00);
      bus(1'b1, `ADDR_STATUS, 8'h00);
      bus(1'b1, 5'h10, 8'h04);
      bus(1'b1, `ADDR_CONTROL, 8'h5A);
      serial_station_i.send(8'h33, 1'b0, 1'b1);
      irqs(8'h00);
      bus(1'b0, `ADDR_STATUS, 8'h00);
      chk("rxfull", rv & 8'h40, 8'h00);
      serial_station_i.send(8'h44, 1'b1, 1'b1);
      irqs(8'h02);
      bus(1'b0, `ADDR_CONTROL, 8'h00);
      chk("await", rv, 8'h52);
      bus(1'b0, `ADDR_STATUS, 8'h00);
      chk("addrbit", rv & 8'h42, 8'h42);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      bus(1'b0, `ADDR_CONTROL, 8'h00);
      chk("reset", rv, 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
